// [bench/rs_systematic_encoder_tb.sv]
// Purpose: self-checking bench of the encoder in fixed length mode
// Assumes: 3-bit symbols, default field polynomial, (7,5) code
// Notes: parity worked out here by long division
`timescale 1ns/10ps
`default_nettype none
`include "rse_encoder_regs.vh"
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin errors++; \
  $display("wrong value at %0t: got %h want %h", $time, a, b); end end
module rs_systematic_encoder_tb;
  logic clk_i = 1'b0, rst_i = 1'b1, ce_i = 1'b1, slow = 1'b1;
  logic wb_cyc = 1'b0, wb_stb = 1'b0, wb_we = 1'b0, wb_ack;
  logic [7:0] wb_adr = 8'h00;
  logic [3:0] wb_sel = 4'h0;
  logic [2:0] ctrl_n = 3'h0;
  logic [1:0] ctrl_r = 2'h0;
  logic [31:0] wb_wdat = 32'h0, wb_rdat, rd;
  logic in_tvalid = 1'b0, in_tlast = 1'b0, in_tready, ctrl_tv = 1'b0;
  logic [2:0] in_tdata = 3'h0, out_tdata;
  logic [0:0] in_tuser = 1'h0, out_tuser;
  logic out_tvalid, out_tready, out_tlast, evt_miss, evt_unexp, evt_ctrl;
  logic [4:0] exp_q[$];
  logic [4:0] exp_w;
  logic [15:0] rnd = 16'h4cd8, ce_rnd = 16'h4cd8;
  int errors = 0, cmp_count = 0, n_miss = 0, n_unexp = 0, n_sent = 0, n_ctrl = 0;
  always #4 clk_i = ~clk_i;

  rse_encoder #(.SW(3), .N_SYM(7), .K_SYM(5), .HAS_CE(1)) i_rse_encoder (
    .clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .resetn_i(1'b1), .wb_cyc_i(wb_cyc),
    .wb_stb_i(wb_stb), .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(wb_sel),
    .wb_dat_i(wb_wdat), .wb_dat_o(wb_rdat), .wb_ack_o(wb_ack), .in_tvalid_i(in_tvalid),
    .in_tready_o(in_tready), .in_tdata_i(in_tdata), .in_tlast_i(in_tlast),
    .in_tuser_i(in_tuser), .ctrl_tvalid_i(ctrl_tv), .ctrl_tready_o(), .ctrl_n_i(ctrl_n),
    .ctrl_r_i(ctrl_r), .out_tvalid_o(out_tvalid), .out_tready_i(out_tready),
    .out_tdata_o(out_tdata), .out_tlast_o(out_tlast), .out_tuser_o(out_tuser),
    .evt_missing_o(evt_miss), .evt_unexpected_o(evt_unexp), .evt_ctrl_invalid_o(evt_ctrl));
  rse_sink_model i_rse_sink_model (.clk_i(clk_i), .rst_i(rst_i), .slow_i(slow),
    .ready_o(out_tready));

  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  // multiply modulo x^3+x+1
  function automatic logic [2:0] gmul(input logic [2:0] a, input logic [2:0] b);
    logic [2:0] p;
    p = 3'h0;
    for (int i = 0; i < 3; i++) begin
      if (b[i]) p = p ^ a;
      a = a[2] ? ((a << 1) ^ 3'h3) : (a << 1);
    end
    return p;
  endfunction

  task automatic tally_and_finish;
    if (errors == 0 && cmp_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic timeout;
    errors++;
    $display("wrong value at %0t: timeout", $time);
    tally_and_finish;
  endtask
  task automatic wb_xfer(input logic we, input logic [7:0] adr, input logic [31:0] wd);
    int w;
    wb_cyc <= 1'b1; wb_stb <= 1'b1; wb_we <= we; wb_adr <= adr; wb_wdat <= wd; wb_sel <= 4'hf;
    w = 0;
    do begin @(posedge clk_i); w++; end while (!wb_ack && w < 100);
    if (!wb_ack) timeout();
    rd = wb_rdat;
    wb_cyc <= 1'b0; wb_stb <= 1'b0; wb_sel <= 4'h0;
    @(posedge clk_i);
  endtask
  task automatic rd_chk(input logic [7:0] adr, input logic [31:0] m, input logic [31:0] e);
    wb_xfer(1'b0, adr, 32'h0);
    `CHK(rd & m, e)
  endtask
  // parity by division with g(x) = (x+1)(x+a) = x^2 + 3x + 2
  task automatic run_block(input int k, input int early, input bit miss);
    logic [2:0] d[8];
    logic t[8];
    logic [2:0] p1, p0, fb;
    int w;
    p1 = 3'h0; p0 = 3'h0;
    for (int i = 0; i < k; i++) begin
      rnd = lfsr(rnd); d[i] = rnd[2:0]; t[i] = rnd[3];
      fb = d[i] ^ p1; p1 = p0 ^ gmul(fb, 3'h3); p0 = gmul(fb, 3'h2);
      exp_q.push_back({d[i], 1'b0, t[i]});
    end
    exp_q.push_back({p1, 1'b0, 1'b0});
    exp_q.push_back({p0, 1'b1, 1'b0});
    for (int i = 0; i < k; i++) begin
      in_tvalid <= 1'b1; in_tdata <= d[i]; in_tuser <= t[i];
      in_tlast <= (i == early) || (i == k - 1 && !miss);
      w = 0;
      do begin @(posedge clk_i); w++; end while (!(in_tready && ce_i) && w < 300);
      if (!(in_tready && ce_i)) timeout();
      n_sent++;
    end
    in_tvalid <= 1'b0; in_tdata <= ~d[k-1]; in_tlast <= 1'b0;
    // one edge with valid low, so a following call never re-drives it in the same step
    @(posedge clk_i);
  endtask
  task automatic drain;
    for (int w = 0; w < 2000 && exp_q.size() > 0; w++) @(posedge clk_i);
    if (exp_q.size() > 0) timeout();
  endtask

  always @(posedge clk_i) begin
    ce_rnd <= lfsr(ce_rnd);
    ce_i <= rst_i || |ce_rnd[1:0];
    ctrl_tv <= ce_rnd[5];
    // fixed mode must ignore whatever sits on the control fields
    ctrl_n <= ce_rnd[8:6];
    ctrl_r <= ce_rnd[10:9];
  end
  always @(posedge clk_i) begin
    if (!rst_i && out_tvalid && out_tready && ce_i) begin
      if (exp_q.size() == 0) timeout();
      exp_w = exp_q.pop_front();
      `CHK({out_tdata, out_tlast, out_tuser}, exp_w)
    end
    if (!rst_i && evt_miss) n_miss++;
    if (!rst_i && evt_unexp) n_unexp++;
    if (!rst_i && evt_ctrl) n_ctrl++;
  end

  initial begin
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    rd_chk(`RSE_ADDR_DEFN, 32'hff, 32'h7);
    rd_chk(`RSE_ADDR_DEFR, 32'hff, 32'h2);
    wb_xfer(1'b1, 8'h40, 32'h5a);
    rd_chk(8'h40, 32'hffffffff, 32'h0);
    run_block(5, -1, 1'b0);
    fork
      run_block(5, 1, 1'b1);
      begin
        for (int w = 0; w < 300 && n_sent < 6; w++) @(posedge clk_i);
        wb_xfer(1'b1, `RSE_ADDR_DEFN, 32'h6);
      end
    join
    drain();
    `CHK(n_miss, 1)
    `CHK(n_unexp, 1)
    `CHK(n_ctrl, 0)
    rd_chk(`RSE_ADDR_EVT, 32'h7, 32'h3);
    wb_xfer(1'b1, `RSE_ADDR_EVT, 32'h3);
    rd_chk(`RSE_ADDR_EVT, 32'h7, 32'h0);
    slow <= 1'b0;
    run_block(4, -1, 1'b0);
    run_block(4, -1, 1'b0);
    drain();
    rd_chk(`RSE_ADDR_STAT, 32'h70000, 32'h60000);
    tally_and_finish();
  end
endmodule // rs_systematic_encoder_tb
`default_nettype wire

// [bench/rse_encoder_checker.sv]
// Purpose: concurrent checks on the encoder ports
// Assumes: fixed block length, one clock domain
// Notes: bound to every encoder instance
`timescale 1ns/10ps
`default_nettype none
module rse_encoder_checker #(
  parameter integer SW = 8,
  parameter integer TAG_W = 1
) (
  input wire logic clk_i,              // clock
  input wire logic rst_i,              // reset
  input wire logic ce_i,               // clock enable
  input wire logic wb_cyc_i,           // bus cycle
  input wire logic wb_stb_i,           // bus strobe
  input wire logic wb_ack_o,           // bus ack
  input wire logic in_tvalid_i,        // input valid
  input wire logic in_tready_o,        // input ready
  input wire logic [SW-1:0] in_tdata_i,    // input symbol
  input wire logic in_tlast_i,         // input last
  input wire logic [TAG_W-1:0] in_tuser_i, // input tag
  input wire logic ctrl_tready_o,      // control ready
  input wire logic out_tvalid_o,       // output valid
  input wire logic out_tready_i,       // output ready
  input wire logic [SW-1:0] out_tdata_o,   // output symbol
  input wire logic out_tlast_o,        // output last
  input wire logic [TAG_W-1:0] out_tuser_o, // output tag
  input wire logic evt_missing_o,      // missing end
  input wire logic evt_unexpected_o    // early end
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  wire take_w = in_tvalid_i && in_tready_o && ce_i;
  wire pop_w = out_tvalid_o && out_tready_i && ce_i;

  property p_no_ctrl; !ctrl_tready_o; endproperty
  a_no_ctrl: assert property (p_no_ctrl) else $error("control ready in fixed mode");
  property p_pass; take_w |=> out_tvalid_o && out_tdata_o == $past(in_tdata_i); endproperty
  a_pass: assert property (p_pass) else $error("info symbol altered");
  property p_tag; take_w |=> out_tuser_o == $past(in_tuser_i); endproperty
  a_tag: assert property (p_tag) else $error("tag misaligned");
  property p_hold;
    out_tvalid_o && !pop_w |=> out_tvalid_o && $stable(out_tdata_o) && $stable(out_tlast_o);
  endproperty
  a_hold: assert property (p_hold) else $error("output dropped while stalled");
  property p_ce; !ce_i |=> $stable(out_tvalid_o) && $stable(in_tready_o); endproperty
  a_ce: assert property (p_ce) else $error("state moved without enable");
  property p_miss; evt_missing_o |-> $past(take_w && !in_tlast_i); endproperty
  a_miss: assert property (p_miss) else $error("missing flag without cause");
  property p_unexp; evt_unexpected_o |-> $past(take_w && in_tlast_i); endproperty
  a_unexp: assert property (p_unexp) else $error("early flag without cause");
  property p_last; pop_w && out_tlast_o |=> !out_tvalid_o; endproperty
  a_last: assert property (p_last) else $error("symbol after block end");
  property p_ack; wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o; endproperty
  a_ack: assert property (p_ack) else $error("bus answer not one cycle");
  c_last_in: cover property (take_w && in_tlast_i);
  c_stall: cover property (out_tvalid_o && !out_tready_i);
  c_miss: cover property (evt_missing_o);
  c_unexp: cover property (evt_unexpected_o);
endmodule // rse_encoder_checker
bind rse_encoder rse_encoder_checker #(.SW(SW), .TAG_W(TAG_W)) i_rse_encoder_checker (
  .clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_ack_o(wb_ack_o), .in_tvalid_i(in_tvalid_i), .in_tready_o(in_tready_o),
  .in_tdata_i(in_tdata_i), .in_tlast_i(in_tlast_i), .in_tuser_i(in_tuser_i),
  .ctrl_tready_o(ctrl_tready_o), .out_tvalid_o(out_tvalid_o), .out_tready_i(out_tready_i),
  .out_tdata_o(out_tdata_o), .out_tlast_o(out_tlast_o), .out_tuser_o(out_tuser_o),
  .evt_missing_o(evt_missing_o), .evt_unexpected_o(evt_unexpected_o));
`default_nettype wire

// [bench/rse_sink_model.sv]
// Purpose: downstream sink with prompt or slow acceptance
// Assumes: one clock
// Notes: ready never depends on valid, so no loop through the encoder
`timescale 1ns/10ps
`default_nettype none
module rse_sink_model (
  input wire logic clk_i,     // clock
  input wire logic rst_i,     // reset
  input wire logic slow_i,    // stall half the time
  output var logic ready_o    // sink ready
);
  logic [1:0] cnt_q;
  always @(posedge clk_i) begin
    cnt_q <= rst_i ? 2'h0 : cnt_q + 2'h1;
    ready_o <= !rst_i && (!slow_i || cnt_q[1]);
  end
endmodule // rse_sink_model
`default_nettype wire

// [src/rse_encoder.v]
// Purpose: systematic block encoder with stream input, control and output
// Assumes: one clock; stream partners run on clk_i; classic bus for registers
// Notes: tags travel with a symbol through the one-stage output register
//
// The register offsets and the Wishbone register port were left to the implementer.
`timescale 1ns/10ps
`default_nettype none
`include "rse_encoder_regs.vh"

module rse_encoder #(
  parameter integer SW = 8,          // symbol width
  parameter integer FIELD_POLY = 0,  // 0 selects default
  parameter integer CODE_SPEC = 0,   // preset selection
  parameter integer N_SYM = 255,     // custom n
  parameter integer K_SYM = 239,     // custom k
  parameter integer GEN_START = 0,   // first root exponent divided by H_SCALE
  parameter integer H_SCALE = 1,     // root exponent step
  parameter integer VAR_N = 0,       // variable block length
  parameter integer VAR_R = 0,       // variable check count
  parameter integer HAS_TREADY = 1,  // output ready used
  parameter integer HAS_CE = 0,      // clock enable used
  parameter integer HAS_RESETN = 0,  // active-low reset used
  parameter integer TAG_W = 1        // marker bits
) (
  input wire clk_i,                    // clock
  input wire rst_i,                    // sync reset, high
  input wire ce_i,                     // clock enable
  input wire resetn_i,                 // optional sync reset, low
  input wire wb_cyc_i,                 // bus cycle
  input wire wb_stb_i,                 // bus strobe
  input wire wb_we_i,                  // bus write
  input wire [7:0] wb_adr_i,           // byte address
  input wire [3:0] wb_sel_i,           // byte lanes
  input wire [31:0] wb_dat_i,          // write data
  output reg [31:0] wb_dat_o,          // read data
  output reg wb_ack_o,                 // bus acknowledge
  input wire in_tvalid_i,              // input symbol valid
  output reg in_tready_o,              // input symbol ready
  input wire [SW-1:0] in_tdata_i,      // information symbol
  input wire in_tlast_i,               // last symbol of block
  input wire [TAG_W-1:0] in_tuser_i,   // marker bits
  input wire ctrl_tvalid_i,            // control word valid
  output reg ctrl_tready_o,            // control word ready
  input wire [SW-1:0] ctrl_n_i,        // block length field
  input wire [$clog2(((CODE_SPEC == 1) ? 16 : (CODE_SPEC == 2) ? 20 : (CODE_SPEC == 3) ? 32 :
    N_SYM - K_SYM) + 1)-1:0] ctrl_r_i, // check count field, RW bits
  output reg out_tvalid_o,             // output symbol valid
  input wire out_tready_i,             // output symbol ready
  output reg [SW-1:0] out_tdata_o,     // code symbol
  output reg out_tlast_o,              // last symbol of block
  output reg [TAG_W-1:0] out_tuser_o,  // marker bits
  output reg evt_missing_o,            // last absent at block end
  output reg evt_unexpected_o,         // last before block end
  output reg evt_ctrl_invalid_o        // illegal control word
);

  function integer poly_default;
    input integer w;
    begin
      case (w)
        3: poly_default = 11;
        4: poly_default = 19;
        5: poly_default = 37;
        6: poly_default = 67;
        7: poly_default = 137;
        8: poly_default = 285;
        9: poly_default = 529;
        10: poly_default = 1033;
        11: poly_default = 2053;
        default: poly_default = 4179;
      endcase
    end
  endfunction

  function integer preset_n;
    input integer spec;
    begin
      case (spec)
        `RSE_SPEC_DVB: preset_n = 204;
        `RSE_SPEC_ATSC: preset_n = 207;
        `RSE_SPEC_CCSDS: preset_n = 255;
        default: preset_n = N_SYM;
      endcase
    end
  endfunction
  function integer preset_k;
    input integer spec;
    begin
      case (spec)
        `RSE_SPEC_DVB: preset_k = 188;
        `RSE_SPEC_ATSC: preset_k = 187;
        `RSE_SPEC_CCSDS: preset_k = 223;
        default: preset_k = K_SYM;
      endcase
    end
  endfunction
  function integer bits_for;
    input integer v;
    integer b;
    begin
      b = 1;
      while ((1 << b) <= v)
        b = b + 1;
      bits_for = b;
    end
  endfunction
  // symbol-wide field; zero picks the default polynomial
  localparam integer FPOLY = (FIELD_POLY == 0) ? poly_default(SW) : FIELD_POLY;
  localparam [SW-1:0] POLY_LO = FPOLY[SW-1:0];
  localparam integer N_DEF = preset_n(CODE_SPEC);
  localparam integer K_DEF = preset_k(CODE_SPEC);
  // check-count width from the default parity count
  localparam integer RW = bits_for(N_DEF - K_DEF);
  localparam integer RMAX = (1 << RW) - 1;
  localparam integer NMAX = (1 << SW) - 1;
  localparam integer VAR_ANY = (VAR_N != 0) || (VAR_R != 0);

  // field multiply, reduced by the field polynomial
  function [SW-1:0] gf_mul;
    input [SW-1:0] a;
    input [SW-1:0] b;
    integer i;
    reg [SW-1:0] acc;
    reg [SW-1:0] aa;
    begin
      acc = {SW{1'b0}};
      aa = a;
      for (i = 0; i < SW; i = i + 1) begin
        if (b[i])
          acc = acc ^ aa;
        aa = aa[SW-1] ? ({aa[SW-2:0], 1'b0} ^ POLY_LO) : {aa[SW-2:0], 1'b0};
      end
      gf_mul = acc;
    end
  endfunction
  function [SW-1:0] gf_pow;
    input integer e;
    integer i;
    reg [SW-1:0] v;
    begin
      v = {{(SW-1){1'b0}}, 1'b1};
      for (i = 0; i < (e % NMAX); i = i + 1)
        v = gf_mul(v, {{(SW-2){1'b0}}, 2'b10});
      gf_pow = v;
    end
  endfunction

  // first root and ratio of consecutive roots
  localparam [SW-1:0] ROOT0 = gf_pow(H_SCALE * GEN_START);
  localparam [SW-1:0] ROOT_STEP = gf_pow(H_SCALE);

  localparam [1:0] ST_IDLE = 2'd0;
  localparam [1:0] ST_SETUP = 2'd1;
  localparam [1:0] ST_DATA = 2'd2;
  localparam [1:0] ST_PAR = 2'd3;

  wire ce = (HAS_CE != 0) ? ce_i : 1'b1;
  // optional low reset joins the main one
  wire rst = rst_i | ((HAS_RESETN != 0) & ~resetn_i);
  // without the ready option the sink always takes
  wire out_rdy = (HAS_TREADY != 0) ? out_tready_i : 1'b1;

  reg [1:0] st_q;
  reg [1:0] st_d;
  reg [11:0] cnt_q;
  reg [SW-1:0] n_q;
  reg [RW-1:0] r_q;
  reg [11:0] k_q;
  reg [SW-1:0] root_q;
  reg [(RMAX+1)*SW-1:0] gen_q;
  reg [RMAX*SW-1:0] par_q;
  reg [SW-1:0] defn_q;
  reg [RW-1:0] defr_q;
  reg [`RSE_EVT_W-1:0] evt_q;
  wire [(RMAX+1)*SW-1:0] gen_nx;
  wire [RMAX*SW-1:0] par_nx;
  wire [RMAX*SW-1:0] par_sh;

  // transfers need valid and ready together
  wire acc_in = in_tvalid_i & in_tready_o & ce;
  wire acc_ctrl = ctrl_tvalid_i & ctrl_tready_o & ce;
  wire out_take = out_tvalid_o & out_rdy;
  wire slot = ~out_tvalid_o | out_take;
  wire par_go = (st_q == ST_PAR) & slot & ce;
  wire last_info = (cnt_q == k_q - 12'd1);
  wire last_par = (cnt_q == {{(12-RW){1'b0}}, r_q} - 12'd1);
  wire [SW-1:0] par_top = par_q[(r_q - 1'b1) * SW +: SW];
  wire [SW-1:0] fb = in_tdata_i ^ par_top;

  // control word fields, defaults where a field is absent
  wire [SW-1:0] c_n = (VAR_N != 0) ? ctrl_n_i : defn_q;
  wire [RW-1:0] c_r = (VAR_R != 0) ? ctrl_r_i : defr_q;
  wire c_ok = (c_n >= `RSE_N_MIN) && (c_r >= `RSE_R_MIN) && (c_r <= `RSE_R_MAX_ABS)
              && ({{(12-RW){1'b0}}, c_r} < {{(12-SW){1'b0}}, c_n});

  genvar gi;
  generate
    for (gi = 0; gi <= RMAX; gi = gi + 1) begin : g_gen
      // multiply generator by (x + root)
      if (gi == 0) begin : g_lo
        assign gen_nx[SW-1:0] = gf_mul(gen_q[SW-1:0], root_q);
      end else begin : g_hi
        assign gen_nx[gi*SW +: SW] = gen_q[(gi-1)*SW +: SW] ^ gf_mul(gen_q[gi*SW +: SW], root_q);
      end
    end
    for (gi = 0; gi < RMAX; gi = gi + 1) begin : g_par
      wire [SW-1:0] below = (gi == 0) ? {SW{1'b0}} : par_q[((gi == 0) ? 0 : gi-1)*SW +: SW];
      wire [SW-1:0] term = (gi < r_q) ? gf_mul(fb, gen_q[gi*SW +: SW]) : {SW{1'b0}};
      // division remainder update per information symbol
      assign par_nx[gi*SW +: SW] = below ^ term;
      assign par_sh[gi*SW +: SW] = below;
    end
  endgenerate

  always @* begin
    st_d = st_q;
    case (st_q)
      ST_IDLE:
        if (VAR_ANY == 0 || acc_ctrl)
          st_d = ST_SETUP;
      ST_SETUP:
        if (ce && cnt_q == {{(12-RW){1'b0}}, r_q})
          st_d = ST_DATA;
      ST_DATA:
        if (acc_in && last_info)
          st_d = ST_PAR;
      ST_PAR:
        if (par_go && last_par)
          st_d = ST_IDLE;
      default:
        st_d = ST_IDLE;
    endcase
  end

  always @(posedge clk_i) begin
    if (rst) begin
      st_q <= ST_IDLE;
      cnt_q <= 12'h000;
      n_q <= {SW{1'b0}};
      r_q <= {RW{1'b0}};
      k_q <= 12'h000;
      root_q <= {SW{1'b0}};
      gen_q <= {(RMAX+1)*SW{1'b0}};
      par_q <= {RMAX*SW{1'b0}};
      in_tready_o <= 1'b0;
      ctrl_tready_o <= 1'b0;
      out_tvalid_o <= 1'b0;
      out_tdata_o <= {SW{1'b0}};
      out_tlast_o <= 1'b0;
      out_tuser_o <= {TAG_W{1'b0}};
      evt_missing_o <= 1'b0;
      evt_unexpected_o <= 1'b0;
      evt_ctrl_invalid_o <= 1'b0;
    end else begin
      evt_missing_o <= 1'b0;
      evt_unexpected_o <= 1'b0;
      evt_ctrl_invalid_o <= 1'b0;
      if (ce)
        st_q <= st_d;
      // control is only taken when a variable option exists
      ctrl_tready_o <= (VAR_ANY != 0) && (st_d == ST_IDLE) && !acc_ctrl;
      // ready is registered, so it rises only when the output slot is sure to be free
      in_tready_o <= (st_d == ST_DATA) && !(acc_in && last_info)
                     && ((HAS_TREADY == 0) || (!acc_in && !(out_tvalid_o && !(out_take && ce))));
      if (st_q == ST_IDLE && st_d == ST_SETUP && ce) begin
        // one control word fixes the whole next block
        if (c_ok) begin
          n_q <= c_n;
          r_q <= c_r;
          k_q <= {{(12-SW){1'b0}}, c_n} - {{(12-RW){1'b0}}, c_r};
        end else begin
          n_q <= defn_q;
          r_q <= defr_q;
          k_q <= {{(12-SW){1'b0}}, defn_q} - {{(12-RW){1'b0}}, defr_q};
        end
        // illegal control word flagged, defaults used
        evt_ctrl_invalid_o <= (VAR_ANY != 0) && !c_ok;
        gen_q <= {{(RMAX*SW){1'b0}}, {{(SW-1){1'b0}}, 1'b1}};
        root_q <= ROOT0;
        cnt_q <= 12'h000;
      end
      if (st_q == ST_SETUP && ce) begin
        if (st_d == ST_DATA) begin
          cnt_q <= 12'h000;
          par_q <= {RMAX*SW{1'b0}};
        end else begin
          // generator rebuilt for this block's parity count
          gen_q <= gen_nx;
          root_q <= gf_mul(root_q, ROOT_STEP);
          cnt_q <= cnt_q + 12'd1;
        end
      end
      if (ce && out_take)
        out_tvalid_o <= 1'b0;
      if (acc_in) begin
        par_q <= par_nx;
        out_tdata_o <= in_tdata_i;
        out_tlast_o <= 1'b0;
        out_tvalid_o <= 1'b1;
        // tag rides the same register as its symbol
        out_tuser_o <= in_tuser_i;
        cnt_q <= last_info ? 12'h000 : cnt_q + 12'd1;
        evt_missing_o <= last_info & ~in_tlast_i;
        evt_unexpected_o <= ~last_info & in_tlast_i;
      end
      // parity leaves only into a free output slot
      if (par_go) begin
        out_tdata_o <= par_top;
        par_q <= par_sh;
        out_tlast_o <= last_par;
        out_tvalid_o <= 1'b1;
        out_tuser_o <= {TAG_W{1'b0}};
        cnt_q <= last_par ? 12'h000 : cnt_q + 12'd1;
      end
    end
  end

  // bus slave: one wait state; a write lands on the edge where the master sees ack
  wire bus_hit = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire bus_wr = wb_cyc_i & wb_stb_i & wb_we_i & wb_ack_o;
  wire [15:0] wmask = {{8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
  wire [15:0] defn_w = ({{(16-SW){1'b0}}, defn_q} & ~wmask) | (wb_dat_i[15:0] & wmask);
  wire [15:0] defr_w = ({{(16-RW){1'b0}}, defr_q} & ~wmask) | (wb_dat_i[15:0] & wmask);
  wire [`RSE_EVT_W-1:0] evt_set = {evt_ctrl_invalid_o, evt_unexpected_o, evt_missing_o};
  wire [`RSE_EVT_W-1:0] evt_clr = (bus_wr && wb_adr_i == `RSE_ADDR_EVT && wb_sel_i[0])
                                  ? wb_dat_i[`RSE_EVT_W-1:0] : {`RSE_EVT_W{1'b0}};

  always @(posedge clk_i) begin
    if (rst) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
      defn_q <= N_DEF[SW-1:0];
      defr_q <= N_DEF[RW-1:0] - K_DEF[RW-1:0];
      evt_q <= {`RSE_EVT_W{1'b0}};
    end else begin
      wb_ack_o <= bus_hit;
      // a new event beats a clear in the same cycle
      evt_q <= (evt_q & ~evt_clr) | evt_set;
      if (bus_wr && wb_adr_i == `RSE_ADDR_DEFN)
        defn_q <= defn_w[SW-1:0];
      if (bus_wr && wb_adr_i == `RSE_ADDR_DEFR)
        defr_q <= defr_w[RW-1:0];
      wb_dat_o <= 32'h0000_0000;
      if (bus_hit && !wb_we_i) begin
        case (wb_adr_i)
          `RSE_ADDR_DEFN: wb_dat_o <= {{(32-SW){1'b0}}, defn_q};
          `RSE_ADDR_DEFR: wb_dat_o <= {{(32-RW){1'b0}}, defr_q};
          `RSE_ADDR_EVT: wb_dat_o <= {{(32-`RSE_EVT_W){1'b0}}, evt_q};
          `RSE_ADDR_STAT: begin
            wb_dat_o[`RSE_STAT_STATE_LSB +: 2] <= st_q;
            wb_dat_o[`RSE_STAT_R_LSB +: RW] <= r_q;
            wb_dat_o[`RSE_STAT_N_LSB +: SW] <= n_q;
          end
          default: wb_dat_o <= 32'h0000_0000;
        endcase
      end
    end
  end

endmodule // rse_encoder

`default_nettype wire

// [src/rse_encoder_regs.vh]
// Purpose: register map and field positions of the systematic block encoder
// Assumes: included by rse_encoder.v and by the testbench
// Notes: byte addresses on a 32-bit classic bus slave
`ifndef RSE_ENCODER_REGS_VH
`define RSE_ENCODER_REGS_VH

// register byte addresses
`define RSE_ADDR_DEFN 8'h00
`define RSE_ADDR_DEFR 8'h04
`define RSE_ADDR_EVT 8'h08
`define RSE_ADDR_STAT 8'h0c
`define RSE_ADDR_W 8

// sticky event bits, write one to clear
`define RSE_EVT_MISSING 0
`define RSE_EVT_UNEXP 1
`define RSE_EVT_CTRL 2
`define RSE_EVT_W 3

// status fields
`define RSE_STAT_STATE_LSB 0
`define RSE_STAT_R_LSB 4
`define RSE_STAT_N_LSB 16

// code legality limits
`define RSE_N_MIN 3
`define RSE_R_MIN 2
`define RSE_R_MAX_ABS 256

// preset code selections
`define RSE_SPEC_CUSTOM 0
`define RSE_SPEC_DVB 1
`define RSE_SPEC_ATSC 2
`define RSE_SPEC_CCSDS 3

`endif
